// file: core/bcrc_pkg.sv
package bcrc_pkg;

  // register map, top eight bytes of the memory space
  localparam logic [16:0] ADDR_CTRL     = 17'h1FFF8;
  localparam logic [16:0] ADDR_SEC      = 17'h1FFF9;
  localparam logic [16:0] ADDR_MIN      = 17'h1FFFA;
  localparam logic [16:0] ADDR_HOUR     = 17'h1FFFB;
  localparam logic [16:0] ADDR_DAY      = 17'h1FFFC;
  localparam logic [16:0] ADDR_DATE     = 17'h1FFFD;
  localparam logic [16:0] ADDR_MONTH    = 17'h1FFFE;
  localparam logic [16:0] ADDR_YEAR     = 17'h1FFFF;

  // clock_control fields
  localparam int          CTRL_LOAD_BIT = 7;
  localparam int          CTRL_READ_BIT = 6;
  localparam int          CTRL_SIGN_BIT = 5;
  localparam int          CAL_MAG_W     = 5;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  // seconds_and_osc_halt fields
  localparam int          SEC_HALT_BIT  = 7;
  localparam logic        HALT_RST      = 1'b1;

  // time field indices, one per time register above the control byte
  localparam int          F_SEC         = 0;
  localparam int          F_MIN         = 1;
  localparam int          F_HOUR        = 2;
  localparam int          F_DAY         = 3;
  localparam int          F_DATE        = 4;
  localparam int          F_MONTH       = 5;
  localparam int          F_YEAR        = 6;
  localparam int          NF            = 7;
  localparam logic [7:0]  FMASK [NF]    = '{8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF};
  localparam logic [7:0]  FLO   [NF]    = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0]  FHI   [NF]    = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  localparam logic [7:0]  FRST  [NF]    = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  // field whose wrap carries into each field; seconds take the tick
  localparam int          CSRC  [NF]    = '{0, 0, 1, 2, 2, 4, 5};

  // timing
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          CLK_HZ         = 1000000000 / CLK_PERIOD_NS;
  localparam int          OSC_HZ         = 32768;
  localparam int          OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;
  localparam int          STAGE_DIV      = 128;
  localparam int          STAGES_PER_SEC = OSC_HZ / STAGE_DIV;
  localparam int          LEN_ADD_STAGES = 2;
  localparam int          LEN_SUB_STAGES = 1;
  localparam int          CAL_CYCLE_MIN  = 64;
  localparam int          CAL_ELIG_MIN   = 62;

  typedef enum logic [1:0] {OSC_HALT, OSC_START, OSC_RUN} bcrc_osc_t;

endpackage

// file: core/bcrc_bcd_step.sv
`timescale 1ns/1ps
module bcrc_bcd_step (
  input  wire logic [7:0] val,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  input  wire logic       inc,
  output logic      [7:0] nxt,
  output logic            wrap
);
  always_comb begin
    nxt  = val;
    wrap = 1'b0;
    if (inc) begin
      // a value above the limit wraps as well, so bad loads recover
      if (val >= hi) begin
        nxt  = lo;
        wrap = 1'b1;
      end else if (val[3:0] >= 4'h9) begin
        nxt = {4'(val[7:4] + 4'h1), 4'h0};
      end else begin
        nxt = {val[7:4], 4'(val[3:0] + 4'h1)};
      end
    end
  end
endmodule // bcrc_bcd_step

// file: core/bcrc_core.sv
// Behaviour
// - the oscillator stops whenever the halt flag, bit 7 of the seconds register, is one.
// - the halt flag comes out of reset at one, so nothing counts until software clears it.
// - once the halt flag is cleared the oscillator runs one second before timekeeping starts.
// - the chain is timed by a 32768 Hz oscillator divided down to a one-second tick.
// - calibration only adds or drops pulses at the divide-by-128 stage, never time registers.
// - control bit 5 picks the sign: one speeds the clock up, zero slows it down.
// - control bits 4 to 0 hold an unsigned calibration magnitude from 0 to 31.
// - correction repeats every 64 minutes, only in the first 62, at most one second a minute.
// - a corrected second is 256 oscillator cycles shorter or 128 cycles longer.
// - a magnitude N corrects exactly the first 2N minutes of the cycle.
// - while control bit 6 is one the registers stop updating but the counters keep going.
// - control bit 7 stops updates and its clearing copies all time registers into the counters.
// - after that copy the next increment comes one full second later in OSC_RUN, two seconds later in OSC_START.
// - time is BCD with a 24-hour clock, and the counters roll over in that coding.
`timescale 1ns/1ps
module bcrc_core
  import bcrc_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        e_b,
  input  wire logic        g_b,
  input  wire logic        w_b,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe
);
  localparam int DW = $clog2(OSC_DIV + 1);
  localparam int MW = $clog2(CAL_CYCLE_MIN);

  // one osc tick per clk is legal: the divider then stays at zero
  if (OSC_DIV < 1) begin : g_bad_div
    $error("OSC_DIV must be at least 1");
  end

  logic [27:0]        pin_s1;
  logic [27:0]        pin_s2;
  logic               e_s;
  logic               g_s;
  logic               w_s;
  logic [16:0]        a_s;
  logic [7:0]         d_s;
  logic               wr_act;
  logic               wr_act_d,   next_wr_act_d;
  logic [16:0]        wr_addr,    next_wr_addr;
  logic [7:0]         wr_data,    next_wr_data;
  logic [7:0]         next_dq_out;
  logic               next_dq_oe;
  logic [7:0]         ctrl,       next_ctrl;
  logic               osc_halt_flag, next_osc_halt_flag;
  logic [7:0]         vis [NF];
  logic [7:0]         next_vis [NF];
  logic [7:0]         cnt [NF];
  logic [7:0]         next_cnt [NF];
  logic [7:0]         stepped [NF];
  logic [NF-1:0]      inc;
  logic [NF-1:0]      wrap;
  logic [DW-1:0]      div,        next_div;
  logic [6:0]         pre,        next_pre;
  logic [8:0]         sc,         next_sc;
  logic [MW-1:0]      min_cyc,    next_min_cyc;
  bcrc_osc_t          state,      next_state;
  logic [7:0]         dmax;
  logic               leap;
  logic               osc_tick;
  logic               osc_on;
  logic               stage_pulse;
  logic               corr_now;
  logic [8:0]         term;
  logic               sec_end;
  logic               sec_tick;
  logic               host_wr;
  logic               wr_hit;
  logic               load_pulse;
  logic               vis_upd;
  logic [CAL_MAG_W-1:0] cal_mag;
  logic               cal_sign;

  // pins come from an asynchronous bus: two flops before any use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= 28'hE000000;
      pin_s2 <= 28'hE000000;
    end else begin
      pin_s1 <= {e_b, g_b, w_b, addr, dq_in};
      pin_s2 <= pin_s1;
    end
  end

  assign e_s      = pin_s2[27];
  assign g_s      = pin_s2[26];
  assign w_s      = pin_s2[25];
  assign a_s      = pin_s2[24:8];
  assign d_s      = pin_s2[7:0];
  assign wr_act   = !e_s && !w_s;
  // a write takes effect at its end, the earlier rising edge of the strobes
  assign host_wr  = wr_act_d && !wr_act;
  assign wr_hit   = host_wr && (wr_addr[16:3] == ADDR_CTRL[16:3]);
  assign cal_mag  = ctrl[CAL_MAG_W-1:0];
  assign cal_sign = ctrl[CTRL_SIGN_BIT];

  assign load_pulse = wr_hit && (wr_addr[2:0] == 3'h0) && ctrl[CTRL_LOAD_BIT]
                      && !wr_data[CTRL_LOAD_BIT];
  assign vis_upd    = sec_tick && !ctrl[CTRL_READ_BIT] && !ctrl[CTRL_LOAD_BIT];

  assign osc_tick    = (div == DW'(OSC_DIV - 1));
  assign osc_on      = (state != OSC_HALT);
  assign stage_pulse = osc_tick && osc_on && (pre == 7'(STAGE_DIV - 1));

  assign corr_now = (state == OSC_RUN) && (cnt[F_SEC] == 8'h00) && (cal_mag != '0)
                    && (min_cyc < {cal_mag, 1'b0})
                    && (min_cyc < MW'(CAL_ELIG_MIN));

  assign term = !corr_now ? 9'(STAGES_PER_SEC)
              : cal_sign  ? 9'(STAGES_PER_SEC - LEN_ADD_STAGES)
              :             9'(STAGES_PER_SEC + LEN_SUB_STAGES);
  assign sec_end  = stage_pulse && (sc == 9'(term - 9'h001));
  assign sec_tick = sec_end && (state == OSC_RUN);

  // leap years and month lengths in BCD
  always_comb begin
    leap = cnt[F_YEAR][4] ? (cnt[F_YEAR][3:0] == 4'h2 || cnt[F_YEAR][3:0] == 4'h6)
         : (cnt[F_YEAR][3:0] == 4'h0 || cnt[F_YEAR][3:0] == 4'h4 || cnt[F_YEAR][3:0] == 4'h8);
    case (cnt[F_MONTH])
      8'h02:                      dmax = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dmax = 8'h30;
      default:                    dmax = FHI[F_DATE];
    endcase
  end

  for (genvar i = 0; i < NF; i++) begin : g_field
    if (i == 0) begin : g_first
      assign inc[i] = sec_tick;
    end else begin : g_chain
      assign inc[i] = wrap[CSRC[i]];
    end
    bcrc_bcd_step u_step (
      .val  (cnt[i]),
      .lo   (FLO[i]),
      .hi   ((i == F_DATE) ? dmax : FHI[i]),
      .inc  (inc[i]),
      .nxt  (stepped[i]),
      .wrap (wrap[i])
    );
  end

  always_comb begin
    next_wr_act_d      = wr_act;
    next_wr_addr       = wr_act ? a_s : wr_addr;
    next_wr_data       = wr_act ? d_s : wr_data;
    next_dq_oe         = !e_s && !g_s && w_s && (a_s[16:3] == ADDR_CTRL[16:3]);
    if (a_s[2:0] == 3'h0) begin
      next_dq_out = ctrl;
    end else if (a_s[2:0] == 3'h1) begin
      next_dq_out = {osc_halt_flag, vis[F_SEC][6:0]};
    end else begin
      next_dq_out = vis[3'(a_s[2:0] - 3'h1)];
    end
    next_ctrl          = ctrl;
    next_osc_halt_flag = osc_halt_flag;
    next_vis           = vis;
    next_cnt           = cnt;
    next_div           = osc_tick ? '0 : DW'(div + 1'b1);
    next_pre           = pre;
    next_sc            = sc;
    next_min_cyc       = min_cyc;
    next_state         = state;
    if (!osc_on || load_pulse) begin
      next_pre = '0;
      next_sc  = '0;
    end else if (osc_tick) begin
      next_pre = 7'(pre + 7'h01);
      if (stage_pulse) begin
        next_sc = sec_end ? 9'h000 : 9'(sc + 9'h001);
      end
    end
    unique case (state)
      OSC_HALT:  if (!osc_halt_flag) next_state = OSC_START;
      OSC_START: if (sec_end) next_state = OSC_RUN;
      OSC_RUN:   next_state = OSC_RUN;
      default:   next_state = OSC_HALT;
    endcase
    if (osc_halt_flag) begin
      next_state = OSC_HALT;
    end
    // minute counter only runs with the clock
    if (sec_tick && wrap[F_SEC]) begin
      next_min_cyc = MW'(min_cyc + 1'b1);
    end
    for (int i = 0; i < NF; i++) begin
      if (load_pulse) begin
        next_cnt[i] = vis[i] & FMASK[i];
      end else if (sec_tick) begin
        next_cnt[i] = stepped[i];
      end
      if (vis_upd) begin
        next_vis[i] = stepped[i];
      end
    end
    // host writes win over a same-cycle update of that byte
    if (wr_hit) begin
      if (wr_addr[2:0] == 3'h0) begin
        next_ctrl = wr_data;
      end else if (wr_addr[2:0] == 3'h1) begin
        next_osc_halt_flag   = wr_data[SEC_HALT_BIT];
        next_vis[F_SEC]      = wr_data & FMASK[F_SEC];
      end else begin
        next_vis[3'(wr_addr[2:0] - 3'h1)] = wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_act_d      <= 1'b0;
      wr_addr       <= 17'h00000;
      wr_data       <= 8'h00;
      dq_out        <= 8'h00;
      dq_oe         <= 1'b0;
      ctrl          <= CTRL_RST;
      osc_halt_flag <= HALT_RST;
      for (int i = 0; i < NF; i++) begin
        vis[i] <= FRST[i];
        cnt[i] <= FRST[i];
      end
      div           <= '0;
      pre           <= 7'h00;
      sc            <= 9'h000;
      min_cyc       <= '0;
      state         <= OSC_HALT;
    end else begin
      wr_act_d      <= next_wr_act_d;
      wr_addr       <= next_wr_addr;
      wr_data       <= next_wr_data;
      dq_out        <= next_dq_out;
      dq_oe         <= next_dq_oe;
      ctrl          <= next_ctrl;
      osc_halt_flag <= next_osc_halt_flag;
      vis           <= next_vis;
      cnt           <= next_cnt;
      div           <= next_div;
      pre           <= next_pre;
      sc            <= next_sc;
      min_cyc       <= next_min_cyc;
      state         <= next_state;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_halt_release;
    osc_halt_flag ##1 !osc_halt_flag;
  endsequence

  a_halt_no_tick: assert property (osc_halt_flag |=> state == OSC_HALT && !sec_tick)
    else $error("clock advanced while halted");
  a_start_delay: assert property (s_halt_release |-> (!sec_tick)[*8])
    else $error("tick too soon after halt release");
  a_stage_align: assert property (stage_pulse |-> osc_tick && pre == 7'h7F)
    else $error("stage pulse off the divide-by-128 boundary");
  a_sign_length: assert property (sec_tick && corr_now |->
      term == (cal_sign ? 9'h0FE : 9'h101))
    else $error("corrected second has wrong length");
  a_cal_window: assert property (corr_now |->
      cal_mag != 0 && min_cyc < 2 * cal_mag && min_cyc < 62)
    else $error("correction outside the minute window");
  a_min_freeze: assert property (state != OSC_RUN |=> $stable(min_cyc))
    else $error("calibration minute moved while not running");
  a_read_hold: assert property (ctrl[CTRL_READ_BIT] && !wr_hit |=> $stable(vis[F_MIN]))
    else $error("register updated during read hold");
  a_load_copy: assert property (load_pulse |=> cnt[F_MIN] == $past(vis[F_MIN] & 8'h7F)
      && sc == 9'h000 && pre == 7'h00)
    else $error("load release did not copy registers");
  a_bcd_digit: assert property (cnt[F_SEC][3:0] <= 4'h9 && cnt[F_HOUR] <= 8'h23)
    else $error("counter left BCD range");

endmodule // bcrc_core

// file: verification/bcrc_host.sv
`timescale 1ns/1ps
module bcrc_host (
  input  wire logic        clk,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe,
  output logic             e_b,
  output logic             g_b,
  output logic             w_b,
  output logic      [16:0] addr,
  output logic      [7:0]  dq_in
);
  initial begin
    e_b = 1'b1;
    g_b = 1'b1;
    w_b = 1'b1;
    addr = 17'h00000;
    dq_in = 8'h00;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobes low 4 cycles and high 5 after, above the 3 the syncs need
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    addr = a;
    dq_in = d;
    e_b = 1'b0;
    w_b = 1'b0;
    gap(4);
    e_b = 1'b1;
    w_b = 1'b1;
    gap(1);
    // released lines must not keep the old value
    addr = ~a;
    dq_in = ~d;
    gap(4);
  endtask
  task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic oe);
    addr = a;
    e_b = 1'b0;
    g_b = 1'b0;
    gap(5);
    d = dq_out;
    oe = dq_oe;
    e_b = 1'b1;
    g_b = 1'b1;
    addr = ~a;
    gap(5);
  endtask
endmodule // bcrc_host

// file: verification/bcrc_core_tb.sv
`timescale 1ns/1ps
module bcrc_core_tb;
  import bcrc_pkg::*;
  // one osc tick per clk keeps two seconds inside the run
  localparam int         DIV     = 1;
  localparam int         SEC_CLK = STAGES_PER_SEC * STAGE_DIV * DIV;
  localparam logic [7:0] CTL_C [3] = '{8'h3F, 8'h1F, 8'h20};
  logic        clk = 1'b0;
  logic        rst_b;
  logic        e_b;
  logic        g_b;
  logic        w_b;
  logic [16:0] addr;
  logic [7:0]  dq_in;
  logic [7:0]  dq_out;
  logic        dq_oe;
  logic [7:0]  rv;
  logic        oe;
  logic [7:0]  v;
  logic [7:0]  tv [NF];
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          t0;
  int          d;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  bcrc_core #(.OSC_DIV(DIV)) i_bcrc_core (
    .clk    (clk),
    .rst_b  (rst_b),
    .e_b    (e_b),
    .g_b    (g_b),
    .w_b    (w_b),
    .addr   (addr),
    .dq_in  (dq_in),
    .dq_out (dq_out),
    .dq_oe  (dq_oe)
  );
  bcrc_host i_bcrc_host (
    .clk    (clk),
    .dq_out (dq_out),
    .dq_oe  (dq_oe),
    .e_b    (e_b),
    .g_b    (g_b),
    .w_b    (w_b),
    .addr   (addr),
    .dq_in  (dq_in)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [16:0] a, input logic [7:0] exp);
    i_bcrc_host.rd(a, rv, oe);
    chk({7'h00, oe}, 8'h01);
    chk(rv, exp);
  endtask
  function automatic logic [7:0] to_bcd(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction
  function automatic int bin(input logic [7:0] b);
    return b[7:4] * 10 + b[3:0];
  endfunction
  // next bcd count, wrapping from the top back to the bottom
  function automatic logic [7:0] bcd_inc(input logic [7:0] x, lo, hi);
    if (x == hi) return lo;
    if (x[3:0] == 4'h9) return {x[7:4] + 4'h1, 4'h0};
    return x + 8'h01;
  endfunction

  initial begin
    rst_b = 1'b0;
    void'($urandom(32'h8732));
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1'b1;
    i_bcrc_host.gap(2);
    rdchk(ADDR_CTRL, CTRL_RST);
    rdchk(ADDR_SEC, {HALT_RST, 7'h00});
    for (int k = 1; k < NF; k++) rdchk(ADDR_SEC + 17'(k), FRST[k]);
    // both signs, magnitude 0 and 31, then random bytes
    for (int i = 0; i < 6; i++) begin
      v = (i < 3) ? CTL_C[i] : 8'($urandom);
      i_bcrc_host.wr(ADDR_CTRL, v);
      rdchk(ADDR_CTRL, v);
    end
    // unmapped place: never driven, never stored
    i_bcrc_host.rd(17'h1FFF7, rv, oe);
    chk({7'h00, oe}, 8'h00);
    i_bcrc_host.wr(17'h0FFF8, ~v);
    rdchk(ADDR_CTRL, v);
    i_bcrc_host.wr(ADDR_CTRL, 8'h80);
    // pass 0 random legal bcd with halt kept, pass 1 every field at its top
    for (int p = 0; p < 2; p++) begin
      for (int k = NF - 1; k >= 0; k--) begin
        tv[k] = to_bcd(bin(FLO[k]) + int'($urandom % (bin(FHI[k]) - bin(FLO[k]) + 1)));
        tv[k] = p ? FHI[k] : tv[k] | ((k == 0) ? 8'h80 : 8'h00);
        i_bcrc_host.wr(ADDR_SEC + 17'(k), tv[k]);
        rdchk(ADDR_SEC + 17'(k), tv[k]);
      end
    end
    t0 = cyc;
    rdchk(ADDR_SEC, 8'h59);
    i_bcrc_host.wr(ADDR_CTRL, 8'h00);
    // start-up second plus the restarted second after the load: about two seconds
    for (int n = 0; n < 7000 && rv === 8'h59; n++) i_bcrc_host.rd(ADDR_SEC, rv, oe);
    d = cyc - t0;
    if (rv === 8'h59) begin
      // a tick that never comes counts as a mismatch
      fail_count++;
    end else begin
      chk({7'h00, d >= SEC_CLK}, 8'h01);
      chk({7'h00, d <= 2 * SEC_CLK + 256}, 8'h01);
      for (int k = 0; k < NF; k++) begin
        rdchk(ADDR_SEC + 17'(k), bcd_inc(FHI[k], FLO[k], FHI[k]));
      end
    end
    test_done();
  end
endmodule // bcrc_core_tb
